// ### pkg/lrs_map.svh
/*
  register offsets, field positions and reset values of the remap and
  link status register group.
  assumes it is included by bare name from design files only.
*/
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH

// register offsets on the local register port
`define LRS_OFS_CFG 8'h04
`define LRS_OFS_BRIDGE 8'h06
`define LRS_OFS_PHYS0 8'h07
`define LRS_OFS_ALIAS0 8'h08
`define LRS_OFS_ERR_LO 8'h0a
`define LRS_OFS_ERR_HI 8'h0b
`define LRS_OFS_STATUS 8'h0c

// field positions
`define LRS_BIT_CLR_CNT 5
`define LRS_BIT_SELFTEST 3
`define LRS_BIT_PCLK 2
`define LRS_BIT_REMOTE 1
`define LRS_BIT_LINK 0
`define LRS_ADDR_MSB 7
`define LRS_ADDR_LSB 1

// reset values
`define LRS_RST_BYTE 8'h00
`define LRS_RST_ADDR7 7'h00
`define LRS_RST_COUNT 16'h0000

// back-channel error counter width
`define LRS_ERR_WIDTH 16

`endif

// ### pkg/lrs_pkg.sv
/*
  types shared by the remap and link status register group.
  assumes lrs_map.svh is compiled alongside; holds no logic.
*/
package lrs_pkg;

  // seven-bit i2c target address
  typedef logic [6:0] lrs_addr7_t;

  // asynchronous link status levels arriving on pins
  typedef struct packed {
    logic link_up;
    logic pclk_ok;
    logic rx_lock;
  } lrs_pins_s;

  // general status byte, msb first
  typedef struct packed {
    logic [3:0] rsvd;
    logic selftest_fail;
    logic pclk_ok;
    logic remote_fail;
    logic link_up;
  } lrs_status_s;

  // where a local transaction goes, one-hot
  typedef enum logic [2:0] {
    ROUTE_NONE = 3'b001,
    ROUTE_BRIDGE = 3'b010,
    ROUTE_ALIAS = 3'b100
  } lrs_route_e;

endpackage : lrs_pkg

// ### rtl/lrs_sync2.sv
/*
  two flip-flop level synchroniser, width set by parameter.
  assumes d comes from outside the clk_sys domain; reset is synchronous.
*/
`timescale 1ns/1ns
module lrs_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // two stages; only q is visible to logic
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : lrs_sync2

// ### rtl/lrs_sat_counter.sv
/*
  saturating event counter with a held clear.
  assumes inc is a one-cycle pulse on clk_sys; clear wins over inc.
*/
`timescale 1ns/1ns
module lrs_sat_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  input wire logic clear,
  input wire logic inc,
  // count value
  output logic [WIDTH-1:0] count
);

  // all ones marks saturation
  wire at_max = &count;
  // increment only below the top value
  wire [WIDTH-1:0] next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

  // clear is a level and holds the count at zero while set
  always_ff @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      count <= '0;
    end else if (inc && !at_max) begin
      count <= next_count;
    end
  end

endmodule : lrs_sat_counter

// ### rtl/lrs_remap_status_regs.sv
/*
  remap and link status register group of the serializer: remote bridge
  target address (learned over the back channel), one alias/physical
  address pair for forwarding, back-channel error counter, general status.
  assumes an i2c slave front end issues one-cycle register strobes on
  clk_sys, and back-channel events arrive as clk_sys pulses; link status
  levels arrive asynchronously on pins.
*/
`timescale 1ns/1ns
`include "lrs_map.svh"

module lrs_remap_status_regs
  import lrs_pkg::*;
#(
  parameter int ERR_WIDTH = `LRS_ERR_WIDTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // local register port from the i2c slave front end
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // asynchronous link status pins
  input wire lrs_pins_s link_pins,
  // back-channel events and the software learn hold, clk_sys domain
  input wire logic bc_learn_valid,
  input wire lrs_addr7_t bc_learn_id,
  input wire logic bc_crc_err,
  input wire logic remote_crc_err,
  input wire logic selftest_active,
  input wire logic selftest_start,
  input wire logic hold_learned_address,
  // local transaction address translation
  input wire logic xlat_req_valid,
  input wire lrs_addr7_t xlat_req_addr,
  output logic xlat_fwd_valid,
  output lrs_addr7_t xlat_fwd_addr,
  output lrs_route_e xlat_route,
  // general status mirror
  output lrs_status_s status_flags
);

  // synchronised link levels
  lrs_pins_s pins_s;
  // remote bridge target address field
  lrs_addr7_t remote_bridge_addr_field;
  // physical address of the far target
  lrs_addr7_t far_target_physical_addr0;
  // alias that selects the far target
  lrs_addr7_t alias_addr0;
  // clear-counters control, not self-clearing
  // it is a stored level, so forgetting to write zero stops all counting
  logic clr_cnt;
  // sticky self-test flags
  logic selftest_backchannel_fail;
  logic remote_selftest_fail;
  // back-channel error count
  logic [ERR_WIDTH-1:0] err_count;

  // link pins cross into clk_sys before anything reads them
  lrs_sync2 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d(link_pins),
    .q(pins_s)
  );

  // register write decode
  wire wr_cfg = reg_wr_en && (reg_addr == `LRS_OFS_CFG);
  wire wr_bridge = reg_wr_en && (reg_addr == `LRS_OFS_BRIDGE);
  wire wr_phys = reg_wr_en && (reg_addr == `LRS_OFS_PHYS0);
  wire wr_alias = reg_wr_en && (reg_addr == `LRS_OFS_ALIAS0);
  // address fields sit in bits 7:1 of the written byte
  wire [6:0] wr_addr7 = reg_wdata[`LRS_ADDR_MSB:`LRS_ADDR_LSB];

  // link loss is the synchronised link level being low
  // a short drop of the pin clears both self-test flags, since there is
  // no debounce beyond the two synchroniser stages
  wire link_lost = !pins_s.link_up;

  // learn after lock
  // learning is gated by lock and by the software hold; a hold that
  // software forgets to set lets the next learn overwrite its value
  wire learn_load = bc_learn_valid && pins_s.rx_lock
                    && !hold_learned_address;

  // bridge address: software write wins over a learn in the same cycle
  // because the write is what software expects to read back
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      remote_bridge_addr_field <= `LRS_RST_ADDR7;
    end else if (wr_bridge) begin
      remote_bridge_addr_field <= wr_addr7;
    end else if (learn_load) begin
      remote_bridge_addr_field <= bc_learn_id;
    end
  end

  // alias pair and clear-counters control, plain software writes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      far_target_physical_addr0 <= `LRS_RST_ADDR7;
      alias_addr0 <= `LRS_RST_ADDR7;
      clr_cnt <= 1'b0;
    end else begin
      if (wr_phys) begin
        far_target_physical_addr0 <= wr_addr7;
      end
      if (wr_alias) begin
        alias_addr0 <= wr_addr7;
      end
      if (wr_cfg) begin
        clr_cnt <= reg_wdata[`LRS_BIT_CLR_CNT];
      end
    end
  end

  // count crc errors
  // clear is the stored control level, so the count stays at zero for
  // as long as software leaves the bit set
  // link loss leaves the count alone so errors around a drop stay visible
  lrs_sat_counter #(
    .WIDTH(ERR_WIDTH)
  ) u_err_count (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(clr_cnt),
    .inc(bc_crc_err),
    .count(err_count)
  );

  // self-test flag set and clear terms
  wire st_set = bc_crc_err && selftest_active;
  wire st_clr = link_lost || selftest_start || clr_cnt;
  wire rm_set = remote_crc_err && selftest_active;
  wire rm_clr = link_lost || clr_cnt;

  // clear on loss, restart
  // a set in the clearing cycle wins so no error goes unseen
  wire next_st = st_set ? 1'b1 : (st_clr ? 1'b0 : selftest_backchannel_fail);
  // remote flag, fewer clears
  // restart of self-test deliberately leaves this flag alone
  wire next_rm = rm_set ? 1'b1 : (rm_clr ? 1'b0 : remote_selftest_fail);

  // sticky flags
  // both flags share one stage so status reads see them move together
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      selftest_backchannel_fail <= 1'b0;
      remote_selftest_fail <= 1'b0;
    end else begin
      selftest_backchannel_fail <= next_st;
      remote_selftest_fail <= next_rm;
    end
  end

  // general status byte as software sees it
  lrs_status_s next_status;
  always_comb begin
    next_status = '0;
    next_status.selftest_fail = selftest_backchannel_fail;
    next_status.pclk_ok = pins_s.pclk_ok;
    next_status.remote_fail = remote_selftest_fail;
    next_status.link_up = pins_s.link_up;
  end

  // status mirror register
  // the mirror shows the same byte in the same cycle as a status read; it saves a register read
  // for logic that only wants to watch the link
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_flags <= '0;
    end else begin
      status_flags <= next_status;
    end
  end

  // a request that matches nothing is not forwarded; the front end must
  // answer it locally or let it go unacknowledged
  // alias compare
  wire alias_hit = (alias_addr0 != `LRS_RST_ADDR7)
                   && (xlat_req_addr == alias_addr0);
  wire bridge_hit = (remote_bridge_addr_field != `LRS_RST_ADDR7)
                    && (xlat_req_addr == remote_bridge_addr_field);

  // route choice; the alias is checked first so a remapped target wins
  // if software ever sets alias and bridge address equal
  wire lrs_route_e next_route = !xlat_req_valid ? ROUTE_NONE :
                                alias_hit ? ROUTE_ALIAS :
                                bridge_hit ? ROUTE_BRIDGE : ROUTE_NONE;

  // forwarded address for each route
  lrs_addr7_t next_fwd_addr;
  always_comb begin
    next_fwd_addr = `LRS_RST_ADDR7;
    case (next_route)
      ROUTE_ALIAS: begin
        next_fwd_addr = far_target_physical_addr0;
      end
      // bridge itself keeps its own address
      ROUTE_BRIDGE: begin
        next_fwd_addr = xlat_req_addr;
      end
      // nothing goes over the back channel
      ROUTE_NONE: begin
        next_fwd_addr = `LRS_RST_ADDR7;
      end
      default: begin
        next_fwd_addr = `LRS_RST_ADDR7;
      end
    endcase
  end

  // translation result, one cycle after the request
  // valid comes from the route so the two outputs can never disagree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      xlat_fwd_valid <= 1'b0;
      xlat_fwd_addr <= `LRS_RST_ADDR7;
      xlat_route <= ROUTE_NONE;
    end else begin
      xlat_fwd_valid <= (next_route != ROUTE_NONE);
      xlat_fwd_addr <= next_fwd_addr;
      xlat_route <= next_route;
    end
  end

  // read selection; reserved bits and unmapped offsets read zero
  // the two error bytes are not latched as a pair: software reading low
  // then high may see a carry in between, so it should read twice
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = `LRS_RST_BYTE;
    case (reg_addr)
      `LRS_OFS_CFG: begin
        next_rdata[`LRS_BIT_CLR_CNT] = clr_cnt;
      end
      `LRS_OFS_BRIDGE: begin
        next_rdata = {remote_bridge_addr_field, 1'b0};
      end
      `LRS_OFS_PHYS0: begin
        next_rdata = {far_target_physical_addr0, 1'b0};
      end
      `LRS_OFS_ALIAS0: begin
        next_rdata = {alias_addr0, 1'b0};
      end
      `LRS_OFS_ERR_LO: begin
        next_rdata = err_count[7:0];
      end
      `LRS_OFS_ERR_HI: begin
        next_rdata = err_count[15:8];
      end
      // live status, the same byte as the mirror output next cycle
      `LRS_OFS_STATUS: begin
        next_rdata = next_status;
      end
      default: begin
        next_rdata = `LRS_RST_BYTE;
      end
    endcase
  end

  // read data stands until the next read strobe
  // reads have no side effects, so a repeated strobe is harmless
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= `LRS_RST_BYTE;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : lrs_remap_status_regs

// ### tb/lrs_assertions.sv
/*
  timing checks on the ports of the remap and status register group.
  assumes link pins stay low while reset is held.
*/
`timescale 1ns/1ns
module lrs_assertions
  import lrs_pkg::*;
#(
  parameter int ERR_WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic reg_rd_en,
  input wire logic reg_rd_valid,
  // pins and events
  input wire lrs_pins_s link_pins,
  input wire logic bc_crc_err,
  input wire logic remote_crc_err,
  input wire logic selftest_active,
  // translation
  input wire logic xlat_req_valid,
  input wire lrs_addr7_t xlat_req_addr,
  input wire logic xlat_fwd_valid,
  input wire lrs_addr7_t xlat_fwd_addr,
  input wire lrs_route_e xlat_route,
  // status mirror
  input wire lrs_status_s status_flags
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe got no answer");
  rd_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read answer without strobe");
  xlat_idle_a: assert property (!xlat_req_valid |=>
    !xlat_fwd_valid && xlat_route == ROUTE_NONE && xlat_fwd_addr == 7'h00)
    else $error("forward without request");
  zero_addr_a: assert property (xlat_req_valid &&
    xlat_req_addr == 7'h00 |=> !xlat_fwd_valid)
    else $error("address zero was forwarded");
  bridge_pass_a: assert property (xlat_route == ROUTE_BRIDGE |->
    xlat_fwd_valid && xlat_fwd_addr == $past(xlat_req_addr))
    else $error("bridge forward address wrong");
  fwd_route_a: assert property (xlat_fwd_valid |->
    xlat_route != ROUTE_NONE)
    else $error("forward without route");
  selftest_flag_a: assert property (selftest_active && bc_crc_err
    |-> ##2 status_flags.selftest_fail)
    else $error("self-test flag not set");
  remote_flag_a: assert property (selftest_active && remote_crc_err
    |-> ##2 status_flags.remote_fail)
    else $error("remote flag not set");
  pclk_lag_a: assert property (
    status_flags.pclk_ok == $past(link_pins.pclk_ok, 3))
    else $error("pixel clock status wrong");
  link_lag_a: assert property (
    status_flags.link_up == $past(link_pins.link_up, 3))
    else $error("link status wrong");
  rsvd_zero_a: assert property (status_flags.rsvd == 4'h0)
    else $error("reserved status bits set");
endmodule : lrs_assertions

bind lrs_remap_status_regs lrs_assertions #(.ERR_WIDTH(ERR_WIDTH)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_rd_en(reg_rd_en),
  .reg_rd_valid(reg_rd_valid), .link_pins(link_pins),
  .bc_crc_err(bc_crc_err), .remote_crc_err(remote_crc_err),
  .selftest_active(selftest_active), .xlat_req_valid(xlat_req_valid),
  .xlat_req_addr(xlat_req_addr), .xlat_fwd_valid(xlat_fwd_valid),
  .xlat_fwd_addr(xlat_fwd_addr), .xlat_route(xlat_route),
  .status_flags(status_flags)
);

// ### tb/lrs_far_bridge.sv
/*
  behavioural remote bridge: link pins and back-channel events.
  assumes tasks are called one step after a rising clock edge.
*/
`timescale 1ns/1ns
module lrs_far_bridge
  import lrs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // back-channel side of the block
  output lrs_pins_s link_pins,
  output logic bc_learn_valid,
  output lrs_addr7_t bc_learn_id,
  output logic bc_crc_err,
  output logic remote_crc_err,
  output logic selftest_active,
  output logic selftest_start
);
  // quiet link, no lock, nothing to report
  initial begin
    link_pins = '0;
    bc_learn_valid = 1'b0;
    bc_learn_id = 7'h55;
    bc_crc_err = 1'b0;
    remote_crc_err = 1'b0;
    selftest_active = 1'b0;
    selftest_start = 1'b0;
  end

  // new pin levels, no alignment needed as they are synchronised
  task automatic pins(input lrs_pins_s p);
    link_pins = p;
  endtask : pins

  // announce a learned bridge address for one cycle
  task automatic learn(input lrs_addr7_t id);
    bc_learn_valid = 1'b1;
    bc_learn_id = id;
    @(posedge clk_sys);
    #1 bc_learn_valid = 1'b0;
    // id is not held after the strobe, so show garbage
    bc_learn_id = ~id;
  endtask : learn

  // n back-to-back crc errors, inside self-test when st is set
  task automatic errs(input int n, input logic st);
    selftest_active = st;
    bc_crc_err = 1'b1;
    remote_crc_err = st;
    repeat (n) @(posedge clk_sys);
    #1 bc_crc_err = 1'b0;
    remote_crc_err = 1'b0;
    selftest_active = 1'b0;
  endtask : errs

  // one-cycle self-test restart
  task automatic restart();
    selftest_start = 1'b1;
    @(posedge clk_sys);
    #1 selftest_start = 1'b0;
  endtask : restart
endmodule : lrs_far_bridge

// ### tb/tb_top.sv
/*
  self-checking bench for the remap and status register group.
  assumes the far bridge model drives every back-channel input.
*/
`timescale 1ns/1ns
module tb_top
  import lrs_pkg::*;
;
  logic clk_sys, reset_n, reg_wr_en, reg_rd_en, reg_rd_valid, xreq_d;
  logic hold_learned_address, xlat_req_valid, xlat_fwd_valid;
  logic bc_learn_valid, bc_crc_err, remote_crc_err;
  logic selftest_active, selftest_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lfsr;
  lrs_addr7_t xlat_req_addr, xlat_fwd_addr, bc_learn_id, phys, alias_id;
  lrs_route_e xlat_route;
  lrs_status_s status_flags;
  lrs_pins_s link_pins;
  int errors = 0;
  int check_count = 0;
  // expected results, oldest first
  logic [7:0] rd_q[$];
  logic [10:0] xl_q[$];
  logic [7:0] ofs[8] = '{8'h04, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b,
    8'h0c, 8'h20};

  lrs_remap_status_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .link_pins(link_pins),
    .bc_learn_valid(bc_learn_valid), .bc_learn_id(bc_learn_id),
    .bc_crc_err(bc_crc_err), .remote_crc_err(remote_crc_err),
    .selftest_active(selftest_active), .selftest_start(selftest_start),
    .hold_learned_address(hold_learned_address),
    .xlat_req_valid(xlat_req_valid), .xlat_req_addr(xlat_req_addr),
    .xlat_fwd_valid(xlat_fwd_valid), .xlat_fwd_addr(xlat_fwd_addr),
    .xlat_route(xlat_route), .status_flags(status_flags));
  lrs_far_bridge u_far (.clk_sys(clk_sys), .link_pins(link_pins),
    .bc_learn_valid(bc_learn_valid), .bc_learn_id(bc_learn_id),
    .bc_crc_err(bc_crc_err), .remote_crc_err(remote_crc_err),
    .selftest_active(selftest_active), .selftest_start(selftest_start));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic chk(input string what, input logic [10:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // one-cycle strobes, entered one step after an edge
  task automatic wr(input logic [7:0] a, d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr_en = 1'b0;
    // let one edge pass so the next strobe is a fresh assignment
    @(posedge clk_sys);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    rd_q.push_back(exp);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1 reg_rd_en = 1'b0;
    // let one edge pass so the next strobe is a fresh assignment
    @(posedge clk_sys);
    #1;
  endtask : rd

  task automatic xl(input lrs_addr7_t a, input lrs_route_e r,
    input lrs_addr7_t fa);
    xl_q.push_back({r != ROUTE_NONE, r, fa});
    xlat_req_valid = 1'b1;
    xlat_req_addr = a;
    @(posedge clk_sys);
    #1 xlat_req_valid = 1'b0;
    // let one edge pass so the next request is a fresh assignment
    @(posedge clk_sys);
    #1;
  endtask : xl

  // remember which cycle carries a translation answer
  always @(posedge clk_sys) xreq_d <= xlat_req_valid;

  // compare answers against the oldest note, at settled mid-cycle
  always @(negedge clk_sys) begin
    if (reg_rd_valid === 1'b1)
      chk("rdata", reg_rdata, rd_q.size() ? rd_q.pop_front() : 'x);
    if (xreq_d === 1'b1)
      chk("xlat", {xlat_fwd_valid, xlat_route, xlat_fwd_addr},
        xl_q.size() ? xl_q.pop_front() : 'x);
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    finish_test();
  end

  initial begin
    {reset_n, reg_wr_en, reg_rd_en, xlat_req_valid} = '0;
    {reg_addr, reg_wdata, xlat_req_addr, hold_learned_address} = '0;
    lfsr = 8'h61;
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(8'h0c, 8'hff);
    wr(8'h0a, 8'hff);
    rd(8'h0c, 8'h00);
    rd(8'h0a, 8'h00);
    lfsr = lfsr_next(lfsr);
    phys = lfsr[6:0] | 7'h01;
    lfsr = lfsr_next(lfsr);
    alias_id = lfsr[6:0] | 7'h40;
    wr(8'h07, {phys, 1'b1});
    wr(8'h08, {alias_id, 1'b1});
    rd(8'h07, {phys, 1'b0});
    rd(8'h08, {alias_id, 1'b0});
    xl(alias_id, ROUTE_ALIAS, phys);
    xl(alias_id ^ 7'h01, ROUTE_NONE, 7'h00);
    u_far.learn(7'h3a);
    rd(8'h06, 8'h00);
    u_far.pins(3'b111);
    repeat (4) @(posedge clk_sys);
    #1 u_far.learn(7'h3a);
    rd(8'h06, 8'h74);
    xl(7'h3a, ROUTE_BRIDGE, 7'h3a);
    rd(8'h0c, 8'h05);
    hold_learned_address = 1'b1;
    u_far.learn(7'h11);
    rd(8'h06, 8'h74);
    wr(8'h06, 8'h44);
    rd(8'h06, 8'h44);
    hold_learned_address = 1'b0;
    wr(8'h08, 8'h00);
    xl(alias_id, ROUTE_NONE, 7'h00);
    wr(8'h06, 8'h00);
    xl(7'h22, ROUTE_NONE, 7'h00);
    xl(7'h00, ROUTE_NONE, 7'h00);
    u_far.errs(3, 1'b1);
    rd(8'h0a, 8'h03);
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h0f);
    u_far.restart();
    rd(8'h0c, 8'h07);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h20);
    u_far.errs(2, 1'b0);
    rd(8'h0a, 8'h00);
    rd(8'h0c, 8'h05);
    wr(8'h04, 8'h00);
    u_far.errs(1, 1'b0);
    rd(8'h0a, 8'h01);
    u_far.errs(1, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1 u_far.pins(3'b011);
    repeat (4) @(posedge clk_sys);
    #1 rd(8'h0c, 8'h04);
    rd(8'h0a, 8'h02);
    u_far.errs(65535, 1'b0);
    rd(8'h0a, 8'hff);
    rd(8'h0b, 8'hff);
    repeat (3) @(posedge clk_sys);
    chk("drain", rd_q.size() + xl_q.size(), 11'h000);
    finish_test();
  end
endmodule : tb_top
